/* File: src/media_object_command_decode.sv */
// media object command decoder with apb registers
`timescale 1ns/1ps
module media_object_command_decode
	import media_cmd_pkg::*;
#(
	parameter int CW = CHUNK_W,
	parameter int FD = FIFO_DEPTH
) (
	input  wire logic          clk,
	input  wire logic          srst,
	input  wire logic          ce,
	input  wire logic [7:0]    paddr,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          cmd_valid,
	input  wire logic [31:0]   cmd_data,
	output logic               cmd_ready,
	output logic               inline_valid,
	output logic [31:0]        inline_data,
	input  wire logic          inline_ready,
	output logic               obj_valid,
	output logic [23:0]        obj_tag,
	output logic [6:0]         obj_desc_index,
	output logic               obj_desc_valid,
	output logic               obj_retain,
	output logic               obj_thread_sync,
	output logic [16:0]        obj_ind_len,
	output logic [31:0]        obj_ind_addr,
	input  wire logic          ind_in_valid,
	input  wire logic [CW-1:0] ind_in_data,
	input  wire logic          ind_in_last,
	output logic               ind_in_ready,
	output logic               ind_out_valid,
	output logic [CW-1:0]      ind_out_data,
	output logic               ind_out_last,
	input  wire logic          ind_out_ready,
	output logic [23:0]        dbg_count
);
	typedef enum logic [5:0] {
		S_HDR    = 6'h01,
		S_TAG    = 6'h02,
		S_IND    = 6'h04,
		S_ADDR   = 6'h08,
		S_INLINE = 6'h10,
		S_SKIP   = 6'h20
	} dec_state_t;

	word_stream_if #(.W(32)) push_s ();

	dec_state_t  state, next_state;
	logic [16:0] rem, next_rem;
	logic [15:0] ninl, next_ninl;
	logic [23:0] next_obj_tag;
	logic [6:0]  next_obj_desc_index;
	logic        next_obj_desc_valid, next_obj_retain, next_obj_thread_sync;
	logic [16:0] next_obj_ind_len;
	logic [31:0] next_obj_ind_addr;
	logic        next_obj_valid, ind_start, next_ind_start;
	fe_mode_t    mode, next_mode;
	logic        enable, next_enable;
	logic [3:0]  err, next_err, err_set;
	logic [23:0] next_dbg_count;
	logic [31:0] obj_count, next_obj_count;
	logic [31:0] next_prdata;
	logic        ind_busy, ind_held, cmd_fire, hdr_ok, len_ok, over_limit;
	logic [15:0] len;
	logic [13:0] inl_units, ind_units;
	logic        apb_wr, apb_setup, mapped;

	assign len      = cmd_data[15:0];
	assign cmd_fire = cmd_valid && cmd_ready;
	// header identity check
	assign hdr_ok = cmd_data[31:29] == CMD_TYPE_GFX && cmd_data[28:27] == PIPE_MEDIA
		&& cmd_data[26:24] == OPC_OBJECT && cmd_data[23:16] == SUBOPC_OBJECT;

	// length acceptance per front-end mode
	always_comb begin
		unique case (mode)
			MODE_VLD:     len_ok = len == LEN_VLD;
			MODE_GENERIC: len_ok = len >= LEN_OVERHEAD
				&& len <= 16'(INLINE_MAX + LEN_OVERHEAD);
			default:      len_ok = len >= LEN_OVERHEAD;
		endcase
	end

	// combined size in 8-dword units, each part rounded up
	assign inl_units  = 14'((17'(ninl) + 17'd7) >> 3);
	assign ind_units  = 14'((18'(cmd_data[ILEN_MSB:0]) + 18'd31) >> 5);
	assign over_limit = mode == MODE_GENERIC && cmd_data[ILEN_MSB:0] != '0
		&& 14'(inl_units + ind_units) > UNIT_MAX;

	// dword stall: header waits on ind_busy, so one right after an address dword is taken before the indirect object starts
	always_comb begin
		if (!ce || !enable) begin
			cmd_ready = 1'b0;
		end else if (state == S_INLINE) begin
			cmd_ready = push_s.ready;
		end else if (state == S_HDR) begin
			cmd_ready = !ind_busy;
		end else begin
			cmd_ready = 1'b1;
		end
	end

	assign push_s.valid = cmd_valid && enable && state == S_INLINE;
	assign push_s.data  = cmd_data;

	// command walk and object fields
	always_comb begin
		next_state           = state;
		next_rem             = rem;
		next_ninl            = ninl;
		next_obj_tag         = obj_tag;
		next_obj_desc_index  = obj_desc_index;
		next_obj_desc_valid  = obj_desc_valid;
		next_obj_retain      = obj_retain;
		next_obj_thread_sync = obj_thread_sync;
		next_obj_ind_len     = obj_ind_len;
		next_obj_ind_addr    = obj_ind_addr;
		next_obj_valid       = 1'b0;
		next_ind_start       = 1'b0;
		err_set              = '0;
		if (cmd_fire) begin
			unique case (state)
				S_HDR: begin
					next_rem  = 17'(len) + 17'd1;
					next_ninl = 16'(len - LEN_OVERHEAD);
					if (!hdr_ok) begin
						err_set[0] = 1'b1;
						next_state = S_SKIP;
					end else if (!len_ok) begin
						err_set[1] = 1'b1;
						next_state = S_SKIP;
					end else begin
						next_rem   = 17'(len);
						next_state = S_TAG;
					end
				end
				S_TAG: begin
					next_obj_tag        = cmd_data[TAG_MSB:TAG_LSB];
					next_obj_desc_valid = mode != MODE_VLD;
					next_obj_desc_index = mode != MODE_VLD ? cmd_data[IDX_MSB:0] : '0;
					next_state          = S_IND;
				end
				S_IND: begin
					next_obj_retain      = cmd_data[RETAIN_BIT];
					next_obj_thread_sync = cmd_data[TSYNC_BIT];
					next_obj_ind_len     = cmd_data[ILEN_MSB:0];
					err_set[2]           = over_limit;
					err_set[3]           = mode == MODE_GENERIC && ninl == '0
						&& cmd_data[ILEN_MSB:0] == '0;
					next_rem             = 17'(rem - 17'd1);
					next_state           = S_ADDR;
				end
				S_ADDR: begin
					next_obj_ind_addr = obj_ind_len != '0 ? cmd_data : '0;
					next_obj_valid    = 1'b1;
					next_ind_start    = obj_ind_len != '0;
					next_rem          = 17'(rem - 17'd1);
					next_state        = rem == 17'd1 ? S_HDR : S_INLINE;
				end
				S_INLINE, S_SKIP: begin
					next_rem   = 17'(rem - 17'd1);
					next_state = rem == 17'd1 ? S_HDR : state;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state           <= S_HDR;
			rem             <= '0;
			ninl            <= '0;
			obj_tag         <= '0;
			obj_desc_index  <= '0;
			obj_desc_valid  <= 1'b0;
			obj_retain      <= 1'b0;
			obj_thread_sync <= 1'b0;
			obj_ind_len     <= '0;
			obj_ind_addr    <= '0;
			obj_valid       <= 1'b0;
			ind_start       <= 1'b0;
		end else if (ce) begin
			state           <= next_state;
			rem             <= next_rem;
			ninl            <= next_ninl;
			obj_tag         <= next_obj_tag;
			obj_desc_index  <= next_obj_desc_index;
			obj_desc_valid  <= next_obj_desc_valid;
			obj_retain      <= next_obj_retain;
			obj_thread_sync <= next_obj_thread_sync;
			obj_ind_len     <= next_obj_ind_len;
			obj_ind_addr    <= next_obj_ind_addr;
			obj_valid       <= next_obj_valid;
			ind_start       <= next_ind_start;
		end
	end

	// apb slave, zero wait states, data latched in setup
	assign pready    = ce;
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite && ce;
	assign mapped    = paddr == REG_CTRL || paddr == REG_STATUS || paddr == REG_DBG
		|| paddr == REG_INFO || paddr == REG_COUNT;
	assign pslverr   = psel && penable && !mapped;

	// register state, hardware set wins over clear
	always_comb begin
		next_mode      = mode;
		next_enable    = enable;
		next_err       = err & ~((apb_wr && paddr == REG_STATUS) ? pwdata[3:0] : 4'h0);
		next_err       = next_err | err_set;
		next_dbg_count = dbg_count;
		next_obj_count = obj_count;
		next_prdata    = prdata;
		if (apb_wr && paddr == REG_CTRL) begin
			next_mode   = pwdata[1:0] == 2'h3 ? mode : fe_mode_t'(pwdata[1:0]);
			next_enable = pwdata[4];
		end
		if (next_obj_valid && cmd_fire) begin
			next_dbg_count = next_obj_tag;
			next_obj_count = 32'(obj_count + 32'd1);
		end else if (ind_out_valid && ind_out_ready) begin
			next_dbg_count = 24'(dbg_count + 24'd1);
		end
		if (apb_setup) begin
			unique case (paddr)
				REG_CTRL:   next_prdata = {27'h0, enable, 2'h0, mode};
				REG_STATUS: next_prdata = {22'h0, ind_held, state != S_HDR || ind_busy,
					4'h0, err};
				REG_DBG:    next_prdata = {8'h00, dbg_count};
				REG_INFO:   next_prdata = {7'h00, ninl[8:0], 7'h00, obj_retain,
					obj_desc_valid, obj_desc_index};
				REG_COUNT:  next_prdata = obj_count;
				default:    next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mode      <= fe_mode_t'(MODE_RESET);
			enable    <= EN_RESET;
			err       <= '0;
			dbg_count <= '0;
			obj_count <= '0;
			prdata    <= '0;
		end else if (ce) begin
			mode      <= next_mode;
			enable    <= next_enable;
			err       <= next_err;
			dbg_count <= next_dbg_count;
			obj_count <= next_obj_count;
			prdata    <= next_prdata;
		end
	end

	stream_fifo #(.WIDTH(32), .DEPTH(FD)) u_inline_fifo (
		.clk       (clk),
		.srst      (srst),
		.ce        (ce),
		.in_s      (push_s),
		.out_valid (inline_valid),
		.out_data  (inline_data),
		.out_ready (inline_ready)
	);

	indirect_retain_unit #(.CHUNK_W(CW)) u_retain (
		.clk       (clk),
		.srst      (srst),
		.ce        (ce),
		.start     (ind_start),
		.retain    (obj_retain),
		.busy      (ind_busy),
		.held      (ind_held),
		.in_valid  (ind_in_valid),
		.in_data   (ind_in_data),
		.in_last   (ind_in_last),
		.in_ready  (ind_in_ready),
		.out_valid (ind_out_valid),
		.out_data  (ind_out_data),
		.out_last  (ind_out_last),
		.out_ready (ind_out_ready)
	);

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_hdr_fire;
		ce && cmd_fire && state == S_HDR;
	endsequence

	property p_bad_hdr;
		s_hdr_fire and !hdr_ok |=> err[0] && state == S_SKIP;
	endproperty
	a_bad_hdr: assert property (p_bad_hdr) else $error("bad header not flagged");

	property p_vld_len;
		s_hdr_fire and hdr_ok && mode == MODE_VLD && len != LEN_VLD |=> err[1];
	endproperty
	a_vld_len: assert property (p_vld_len) else $error("vld length not checked");

	property p_gen_accept;
		s_hdr_fire and hdr_ok && mode == MODE_GENERIC && len >= 16'd2 && len <= 16'd506
			|=> state == S_TAG && rem == 17'($past(len));
	endproperty
	a_gen_accept: assert property (p_gen_accept) else $error("generic length refused");

	property p_tag_load;
		obj_valid |-> dbg_count == obj_tag;
	endproperty
	a_tag_load: assert property (p_tag_load) else $error("debug counter not loaded");

	property p_desc_idx;
		ce && cmd_fire && state == S_TAG && mode != MODE_VLD
			|=> obj_desc_index == $past(cmd_data[6:0]) && obj_desc_valid;
	endproperty
	a_desc_idx: assert property (p_desc_idx) else $error("descriptor index wrong");

	property p_vld_ignore;
		obj_valid && mode == MODE_VLD |-> !obj_desc_valid && obj_desc_index == 7'h00;
	endproperty
	a_vld_ignore: assert property (p_vld_ignore) else $error("vld index used");

	property p_retain_bit;
		ce && cmd_fire && state == S_IND |=> obj_retain == $past(cmd_data[28]);
	endproperty
	a_retain_bit: assert property (p_retain_bit) else $error("retain decode wrong");

	property p_ind_zero;
		obj_valid |-> ind_start == (obj_ind_len != 17'h0)
			&& (obj_ind_len != 17'h0 || obj_ind_addr == 32'h0);
	endproperty
	a_ind_zero: assert property (p_ind_zero) else $error("zero length fetch");

	property p_limit;
		ce && cmd_fire && state == S_IND && over_limit |=> err[2];
	endproperty
	a_limit: assert property (p_limit) else $error("size limit not flagged");
endmodule : media_object_command_decode

/* File: common/media_cmd_pkg.sv */
// constants and types for the media object command decoder
package media_cmd_pkg;
	// command header identity
	localparam logic [2:0]  CMD_TYPE_GFX  = 3'h3;
	localparam logic [1:0]  PIPE_MEDIA    = 2'h2;
	localparam logic [2:0]  OPC_OBJECT    = 3'h1;
	localparam logic [7:0]  SUBOPC_OBJECT = 8'h00;
	// length field limits in dwords, combined size limit in 8-dword units
	localparam logic [15:0] LEN_VLD       = 16'h0004;
	localparam logic [15:0] LEN_OVERHEAD  = 16'h0002;
	localparam logic [15:0] INLINE_MAX    = 16'h01F8;
	localparam logic [13:0] UNIT_MAX      = 14'h003F;
	// field positions
	localparam int TAG_MSB    = 31;
	localparam int TAG_LSB    = 8;
	localparam int IDX_MSB    = 6;
	localparam int RETAIN_BIT = 28;
	localparam int TSYNC_BIT  = 24;
	localparam int ILEN_MSB   = 16;
	// register byte offsets
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_STATUS = 8'h04;
	localparam logic [7:0]  REG_DBG    = 8'h08;
	localparam logic [7:0]  REG_INFO   = 8'h0C;
	localparam logic [7:0]  REG_COUNT  = 8'h10;
	// values after reset
	localparam logic [1:0]  MODE_RESET = 2'h0;
	localparam logic        EN_RESET   = 1'b1;
	// buffering
	localparam int FIFO_DEPTH = 16;
	localparam int CHUNK_W    = 256;
	typedef enum logic [1:0] {
		MODE_GENERIC = 2'h0,
		MODE_IS      = 2'h1,
		MODE_VLD     = 2'h2
	} fe_mode_t;
endpackage : media_cmd_pkg

/* File: common/word_stream_if.sv */
// valid/ready word stream between internal modules
`timescale 1ns/1ps
interface word_stream_if #(parameter int W = 32);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : word_stream_if

/* File: src/stream_fifo.sv */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module stream_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             ce,
	word_stream_if.snk            in_s,
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr, next_wr_ptr;
	logic [AW-1:0]    rd_ptr, next_rd_ptr;
	logic [CW-1:0]    count, next_count;
	logic             push, pop;

	// honest full and empty, frozen while ce is low
	assign in_s.ready = ce && (count != CW'(DEPTH));
	assign out_valid  = ce && (count != '0);
	assign out_data   = mem[rd_ptr];
	assign push       = in_s.valid && in_s.ready;
	assign pop        = out_valid && out_ready;

	// pointer and fill arithmetic
	always_comb begin
		next_wr_ptr = push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
		next_rd_ptr = pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
		next_count  = CW'(count + CW'(push) - CW'(pop));
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (ce) begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// storage, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_s.data;
		end
	end
endmodule : stream_fifo

/* File: src/indirect_retain_unit.sv */
// indirect chunk pass-through with carry-over of the last chunk
`timescale 1ns/1ps
module indirect_retain_unit #(
	parameter int CHUNK_W = 256
) (
	input  wire logic               clk,
	input  wire logic               srst,
	input  wire logic               ce,
	input  wire logic               start,
	input  wire logic               retain,
	output logic                    busy,
	output logic                    held,
	input  wire logic               in_valid,
	input  wire logic [CHUNK_W-1:0] in_data,
	input  wire logic               in_last,
	output logic                    in_ready,
	output logic                    out_valid,
	output logic [CHUNK_W-1:0]      out_data,
	output logic                    out_last,
	input  wire logic               out_ready
);
	logic               active, next_active;
	logic               first_pend, next_first_pend;
	logic               retain_q, next_retain_q;
	logic               next_held;
	logic [CHUNK_W-1:0] held_data, next_held_data;
	logic               ov, next_ov;
	logic [CHUNK_W-1:0] next_out_data;
	logic               next_out_last;
	logic               load, in_fire;

	assign load      = !ov || out_ready;
	assign in_ready  = ce && active && !first_pend && load;
	assign in_fire   = in_valid && in_ready;
	assign out_valid = ov && ce;
	assign busy      = active || ov;

	// object sequencing and chunk carry-over
	always_comb begin
		next_active     = active;
		next_first_pend = first_pend;
		next_retain_q   = retain_q;
		next_held       = held;
		next_held_data  = held_data;
		next_ov         = ov && !out_ready;
		next_out_data   = out_data;
		next_out_last   = out_last;
		if (start) begin
			next_active     = 1'b1;
			next_first_pend = held;
			next_retain_q   = retain;
		end
		if (active && first_pend && load) begin
			next_ov         = 1'b1; // retained chunk goes out first
			next_out_data   = held_data;
			next_out_last   = 1'b0;
			next_first_pend = 1'b0;
			next_held       = 1'b0;
		end
		if (in_fire) begin
			next_ov       = 1'b1;
			next_out_data = in_data;
			next_out_last = in_last;
			if (in_last) begin
				next_active = 1'b0;
				next_held   = retain_q;
				if (retain_q) begin
					next_held_data = in_data;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			active     <= 1'b0;
			first_pend <= 1'b0;
			retain_q   <= 1'b0;
			held       <= 1'b0;
			held_data  <= '0;
			ov         <= 1'b0;
			out_data   <= '0;
			out_last   <= 1'b0;
		end else if (ce) begin
			active     <= next_active;
			first_pend <= next_first_pend;
			retain_q   <= next_retain_q;
			held       <= next_held;
			held_data  <= next_held_data;
			ov         <= next_ov;
			out_data   <= next_out_data;
			out_last   <= next_out_last;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	property p_keep_last;
		ce && in_fire && in_last && retain_q |=> held && held_data == $past(in_data);
	endproperty
	a_keep_last: assert property (p_keep_last) else $error("last chunk not kept");

	// the held chunk is the first one out, never flagged as last
	property p_held_first;
		ce && active && first_pend && load
			|=> ov && out_data == $past(held_data) && !out_last;
	endproperty
	a_held_first: assert property (p_held_first) else $error("new data before held chunk");
endmodule : indirect_retain_unit

/* File: bench/cmd_source.sv */
// command stream source standing in for the driver-built command buffer
`timescale 1ns/1ps
module cmd_source (
	input  wire logic   clk,
	input  wire logic   srst,
	output logic        cmd_valid,
	output logic [31:0] cmd_data,
	input  wire logic   cmd_ready
);
	logic [31:0] q[$];

	// queue header, tag word, length word, address, then n inline dwords
	task obj(input logic [31:0] h, input logic [23:0] tag, input logic [6:0] idx,
		input logic ret, input logic [16:0] ilen, input int n);
		q.push_back(h);
		q.push_back({tag, 1'b0, idx});
		q.push_back({3'h0, ret, 11'h000, ilen});
		q.push_back(32'h0BAD_F00D);
		for (int i = 0; i < n; i++)
			q.push_back(32'hC0DE_0000 + i);
	endtask : obj

	initial begin
		cmd_valid = 1'b0;
		cmd_data  = 32'h0;
	end

	// hold each dword until taken; scramble the data lines while idle
	always @(posedge clk) begin
		if (srst) begin
			cmd_valid <= 1'b0;
		end else if (!cmd_valid || cmd_ready) begin
			if (q.size() > 0) begin
				cmd_valid <= 1'b1;
				cmd_data  <= q.pop_front();
			end else begin
				cmd_valid <= 1'b0;
				cmd_data  <= ~cmd_data;
			end
		end
	end
endmodule : cmd_source

/* File: bench/media_object_command_decode_tb_top.sv */
// testbench for the media object command decoder
`timescale 1ns/1ps
module media_object_command_decode_tb_top;
	import media_cmd_pkg::*;
	logic         clk = 1'b0;
	logic         srst = 1'b1;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic [7:0]   paddr = 8'h00;
	logic [31:0]  pwdata = 32'h0;
	logic         ind_in_valid = 1'b0;
	logic [255:0] ind_in_data = '0;
	logic         ind_in_last = 1'b0;
	logic [31:0]  prdata, cmd_data, inline_data, obj_ind_addr, rd;
	logic         pready, pslverr, cmd_valid, cmd_ready, inline_valid, obj_valid, err;
	logic         obj_desc_valid, obj_retain, ind_in_ready, ind_out_valid;
	logic [23:0]  obj_tag, dbg_count;
	logic [6:0]   obj_desc_index;
	logic [16:0]  obj_ind_len;
	logic         ind_out_last;
	logic [255:0] ind_out_data;
	logic [31:0]  inl_q[$];
	logic [255:0] ind_q[$];
	int           mismatches = 0;
	int           cmp_count = 0;
	int           n_obj = 0;
	int           cycles = 0;
	int           sh[4] = '{29, 27, 24, 16};
	int           ex[4] = '{1, 2, 2, 3};

	always #4 clk = ~clk;

	cmd_source cmd_source_inst (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready));

	media_object_command_decode media_object_command_decode_inst (
		.clk(clk), .srst(srst), .ce(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
		.cmd_ready(cmd_ready), .inline_valid(inline_valid), .inline_data(inline_data),
		.inline_ready(1'b1), .obj_valid(obj_valid), .obj_tag(obj_tag),
		.obj_desc_index(obj_desc_index), .obj_desc_valid(obj_desc_valid),
		.obj_retain(obj_retain), .obj_thread_sync(), .obj_ind_len(obj_ind_len),
		.obj_ind_addr(obj_ind_addr), .ind_in_valid(ind_in_valid),
		.ind_in_data(ind_in_data), .ind_in_last(ind_in_last), .ind_in_ready(ind_in_ready),
		.ind_out_valid(ind_out_valid), .ind_out_data(ind_out_data),
		.ind_out_last(ind_out_last),
		.ind_out_ready(1'b1), .dbg_count(dbg_count));

	function automatic logic [31:0] hdr(input logic [15:0] len);
		return {CMD_TYPE_GFX, PIPE_MEDIA, OPC_OBJECT, SUBOPC_OBJECT, len};
	endfunction : hdr

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk

	task give_verdict;
		$display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict

	// one apb transfer; read data and error taken at the completing edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// offer one fetched chunk and hold it until taken
	task ind_send(input int k, input logic last);
		@(posedge clk);
		ind_in_valid <= 1'b1;
		ind_in_data  <= {8{32'hA000_0000 + k}};
		ind_in_last  <= last;
		@(posedge clk);
		while (ind_in_ready !== 1'b1)
			@(posedge clk);
		ind_in_valid <= 1'b0;
		ind_in_data  <= ~ind_in_data;
		ind_in_last  <= 1'b0;
	endtask : ind_send

	task settle;
		while (cmd_source_inst.q.size() != 0 || cmd_valid === 1'b1)
			@(posedge clk);
		repeat (6) @(posedge clk);
	endtask : settle

	task chk_inl(input int n);
		chk(inl_q.size(), n);
		for (int i = 0; i < n; i++)
			chk(inl_q[i], 32'hC0DE_0000 + i);
		inl_q.delete();
	endtask : chk_inl

	// collect outputs and cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (obj_valid === 1'b1)
			n_obj++;
		if (inline_valid === 1'b1)
			inl_q.push_back(inline_data);
		if (ind_out_valid === 1'b1)
			ind_q.push_back(ind_out_data);
		if (cycles > 5000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		apb(0, REG_CTRL, 0);
		chk(rd, 32'h0000_0010);
		apb(0, REG_STATUS, 0);
		chk(rd, 32'h0);
		apb(0, 8'h20, 0);
		chk({rd[30:0], err}, 32'h1);
		// plain generic object, then the largest inline count
		cmd_source_inst.obj(hdr(16'h0005), 24'h123456, 7'h55, 1'b0, 17'h0, 3);
		settle();
		chk(n_obj, 1);
		chk(obj_tag, 24'h123456);
		chk(dbg_count, 24'h123456);
		chk({obj_desc_valid, obj_desc_index}, 8'hD5);
		chk(obj_ind_addr, 32'h0);
		chk_inl(3);
		cmd_source_inst.obj(hdr(16'h01FA), 24'h000001, 7'h00, 1'b0, 17'h0, 504);
		settle();
		chk(n_obj, 2);
		chk_inl(504);
		// each header field wrong, a short length, then a good object
		for (int i = 0; i < 4; i++)
			cmd_source_inst.obj(hdr(16'h0002) ^ (32'h1 << sh[i]), 24'h0, 7'h0, 1'b0, 17'h0, 0);
		cmd_source_inst.q.push_back(hdr(16'h0001));
		cmd_source_inst.q.push_back(32'h0);
		cmd_source_inst.q.push_back(32'h0);
		cmd_source_inst.obj(hdr(16'h0003), 24'hABCDEF, 7'h01, 1'b0, 17'h0, 1);
		settle();
		chk(n_obj, 3);
		chk_inl(1);
		apb(0, REG_STATUS, 0);
		chk(rd[1:0], 2'h3);
		apb(1, REG_STATUS, 32'h0000_000F);
		// no inline and no indirect data is flagged
		cmd_source_inst.obj(hdr(16'h0002), 24'h000100, 7'h00, 1'b0, 17'h0, 0);
		settle();
		apb(0, REG_STATUS, 0);
		chk({n_obj[7:0], rd[3]}, 9'h009);
		apb(1, REG_STATUS, 32'h0000_000F);
		// retained chunk carried into the next indirect object
		cmd_source_inst.obj(hdr(16'h0002), 24'h000200, 7'h02, 1'b1, 17'h00040, 0);
		ind_send(1, 1'b0);
		ind_send(2, 1'b1);
		settle();
		apb(0, REG_STATUS, 0);
		chk({rd[9], rd[3]}, 2'h2);
		cmd_source_inst.obj(hdr(16'h0003), 24'h000300, 7'h03, 1'b0, 17'h00020, 1);
		ind_send(3, 1'b1);
		settle();
		chk(dbg_count, 24'h000302);
		chk({ind_out_last, obj_ind_len}, {1'b1, 17'h00020});
		apb(0, REG_STATUS, 0);
		chk(rd[9], 1'b0);
		chk(ind_q.size(), 4);
		for (int i = 0; i < 4; i++)
			chk(ind_q[i][255:224], 32'hA000_0000 + ex[i]);
		chk_inl(1);
		// one inline unit plus 63 indirect units is flagged, object still runs
		cmd_source_inst.obj(hdr(16'h000A), 24'h000600, 7'h06, 1'b0, 17'h007E0, 8);
		ind_send(4, 1'b1);
		settle();
		apb(0, REG_STATUS, 0);
		chk({n_obj[7:0], rd[2]}, 9'h00F);
		chk_inl(8);
		apb(1, REG_STATUS, 32'h0000_000F);
		// variable length decode mode; mode value 3 is not taken
		apb(1, REG_CTRL, 32'h0000_0012);
		apb(1, REG_CTRL, 32'h0000_0013);
		apb(0, REG_CTRL, 0);
		chk(rd, 32'h0000_0012);
		cmd_source_inst.obj(hdr(16'h0004), 24'h000400, 7'h2A, 1'b0, 17'h0, 2);
		cmd_source_inst.obj(hdr(16'h0005), 24'h000500, 7'h2A, 1'b0, 17'h0, 3);
		settle();
		chk(n_obj, 8);
		chk(obj_desc_index, 7'h00);
		chk_inl(2);
		apb(0, REG_STATUS, 0);
		chk(rd[1], 1'b1);
		apb(0, REG_COUNT, 0);
		chk(rd, 32'h0000_0008);
		give_verdict();
	end
endmodule : media_object_command_decode_tb_top
